/* retimer_int_and_load_ctrl.sv */
// Purpose: Register front end, per-channel interrupt status and resets
// Assumes: One-cycle register strobes from the serial slave, inputs synchronous
// Notes:   Read data is valid one cycle after the read strobe
`timescale 1ns/10ps
module retimer_int_and_load_ctrl
  import retimer_pkg::*;
(
  input  wire logic        clk_in,           // Core clock, 100 MHz
  input  wire logic        srst_in,          // Synchronous reset, active high
  input  wire logic        bus_role_strap_in,// 1 selects slave mode
  input  wire logic        load_req_n_in,    // Load request pin, active low
  input  wire logic        fetch_done_in,    // Fetch engine completion pulse
  input  wire logic [7:0]  reg_addr_in,      // Register offset
  input  wire logic        reg_wr_in,        // Write strobe
  input  wire logic        reg_rd_in,        // Read strobe
  input  wire logic [7:0]  reg_wdata_in,     // Write data
  input  wire logic [3:0]  lock_in,          // CDR lock per channel
  input  wire logic [3:0]  sig_det_in,       // Signal detect per channel
  input  wire logic [31:0] horizontal_eye_opening_in, // Byte per channel
  input  wire logic [31:0] vertical_eye_opening_in,   // Byte per channel
  output logic      [7:0]  reg_rdata_out,    // Read data
  output logic             fetch_req_out,    // Fetch in progress
  output logic             int_n_out,        // Open-drain data, always low
  output logic             int_n_oe_out,     // High while pulling line low
  output logic      [3:0]  ch_reset_out,     // Channel defaults restored pulse
  output logic      [3:0]  cdr_hold_out,     // CDR machine held in reset
  output logic      [3:0]  cdr_restart_out,  // Lock acquisition restart pulse
  output logic      [7:0]  adapt_mode_out    // Two bits per channel
);
  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  logic [2:0]        sel_reg;        // Page enable and channel number
  logic              mm_reset_reg;   // Master-mode reset, held by host
  logic              mm_disable_reg; // Master-mode disable
  logic              strap_seen_reg; // Strap captured after release
  logic              master_reg;     // Captured bus role, 1 for master
  logic              imm_go_reg;     // Immediate fetch strobe
  logic [7:0]        rdata_reg;      // Registered read data
  logic              int_oe_reg;     // Registered interrupt drive
  logic [NUM_CH-1:0] pend;           // Per-channel pending status
  logic [7:0]        ch_rdata [NUM_CH]; // Per-channel read mux
  logic              page_ch;        // Channel page selected
  logic [1:0]        cur_ch;         // Selected channel
  logic              sh_wr;          // Write to shared page
  load_ctrl_if       lc ();          // Load controller carrier

  assign page_ch = sel_reg[BIT_PAGE_EN];
  assign cur_ch  = sel_reg[1:0];
  assign sh_wr   = reg_wr_in && !page_ch;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Caught on the first edge after release, never under reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      strap_seen_reg <= 1'b0;
      master_reg     <= 1'b0;
    end else if (!strap_seen_reg) begin
      strap_seen_reg <= 1'b1;
      master_reg     <= ~bus_role_strap_in;
    end
  end

  // ----------------------------------------------------------------
  // Channel select register
  // ----------------------------------------------------------------
  // Written from either page so the host can always leave a page
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sel_reg <= RST_CH_SELECT;
    end else if (reg_wr_in && reg_addr_in == OFS_CH_SELECT) begin
      sel_reg <= reg_wdata_in[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Shared load control bits
  // ----------------------------------------------------------------
  // Reset bit is level and not self-clearing; host must drop it
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mm_reset_reg <= 1'b0;
    end else if (sh_wr && reg_addr_in == OFS_LOAD_CTRL) begin
      mm_reset_reg <= reg_wdata_in[BIT_MM_RESET];
    end
  end

  // Immediate fetch is a strobe; the bit reads back as zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      imm_go_reg <= 1'b0;
    end else begin
      imm_go_reg <= sh_wr && reg_addr_in == OFS_LOAD_CTRL && reg_wdata_in[BIT_IMM_FETCH];
    end
  end

  // Disable only matters while the sequencer idles
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mm_disable_reg <= 1'b0;
    end else if (sh_wr && reg_addr_in == OFS_IRQ_FLAGS) begin
      mm_disable_reg <= reg_wdata_in[BIT_MM_DISABLE];
    end
  end

  assign lc.imm_go     = imm_go_reg;
  assign lc.mm_reset   = mm_reset_reg;
  assign lc.mm_disable = mm_disable_reg;

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  eeprom_load_ctrl u_load (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .master_mode_in (master_reg),
    .load_req_n_in  (load_req_n_in),
    .fetch_done_in  (fetch_done_in),
    .lc             (lc.load)
  );

  // Request follows the sequencer state one cycle late
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fetch_req_out <= 1'b0;
    end else begin
      fetch_req_out <= lc.fetch_req && !mm_reset_reg;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel logic
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      logic       hit;        // This channel selected
      logic       wr;         // Write to this channel
      logic       rd;         // Read from this channel
      logic       soft_rst;   // Restore defaults this cycle
      logic       lol_set;    // Lock lost event
      logic       los_set;    // Signal lost event
      logic       below;      // Eye under threshold
      logic       eye_set;    // Eye drop event
      logic [7:0] horizontal_eye_opening;        // Horizontal opening
      logic [7:0] vertical_eye_opening;        // Vertical opening
      logic       lock_q;     // Previous lock
      logic       sig_q;      // Previous signal detect
      logic       below_q;    // Previous eye comparison
      logic       lol_reg;    // Cause bit, lock loss
      logic       los_reg;    // Cause bit, signal loss
      logic       eye_reg;    // Eye status bit
      logic [1:0] ovr_reg;    // Override enable and hold
      logic [1:0] adapt_reg;  // Adapt mode
      logic [7:0] thr_reg;    // Eye threshold
      logic       eye_en_reg; // Eye interrupt enable
      logic       hold_q;     // Previous hold for release detect

      assign hit = page_ch && cur_ch == 2'(i);
      assign wr  = reg_wr_in && hit;
      assign rd  = reg_rd_in && hit;
      assign horizontal_eye_opening = horizontal_eye_opening_in[8*i +: 8];
      assign vertical_eye_opening = vertical_eye_opening_in[8*i +: 8];
      assign soft_rst = wr && reg_addr_in == OFS_SOFT_RESET && reg_wdata_in[BIT_CH_SOFT_RST];

      // Edge detection history, so a stuck fault is one event
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          lock_q  <= 1'b0;
          sig_q   <= 1'b0;
          below_q <= 1'b0;
        end else begin
          lock_q  <= lock_in[i];
          sig_q   <= sig_det_in[i];
          below_q <= below;
        end
      end

      assign lol_set = lock_q && !lock_in[i];
      assign los_set = sig_q && !sig_det_in[i];
      assign below   = (horizontal_eye_opening < thr_reg) || (vertical_eye_opening < thr_reg);
      assign eye_set = eye_en_reg && below && !below_q;

      // Cause bits; a new event beats a read in the same cycle
      always_ff @(posedge clk_in) begin
        if (srst_in || soft_rst) begin
          lol_reg <= 1'b0;
          los_reg <= 1'b0;
        end else begin
          lol_reg <= lol_set || (lol_reg && !(rd && reg_addr_in == OFS_IRQ_CAUSE));
          los_reg <= los_set || (los_reg && !(rd && reg_addr_in == OFS_IRQ_CAUSE));
        end
      end

      // Eye status bit, same set-wins policy
      always_ff @(posedge clk_in) begin
        if (srst_in || soft_rst) begin
          eye_reg <= 1'b0;
        end else begin
          eye_reg <= eye_set || (eye_reg && !(rd && reg_addr_in == OFS_EYE_STATUS));
        end
      end

      // Configuration registers of the channel
      always_ff @(posedge clk_in) begin
        if (srst_in || soft_rst) begin
          ovr_reg    <= 2'h0;
          adapt_reg  <= RST_ADAPT_MODE;
          thr_reg    <= RST_EYE_THRESH;
          eye_en_reg <= 1'b0;
        end else if (wr) begin
          case (reg_addr_in)
            OFS_CDR_OVR:    ovr_reg    <= {reg_wdata_in[BIT_OVR_EN], reg_wdata_in[BIT_OVR_HOLD]};
            OFS_ADAPT_MODE: adapt_reg  <= reg_wdata_in[ADAPT_HI:ADAPT_LO];
            OFS_EYE_THRESH: thr_reg    <= reg_wdata_in;
            OFS_EYE_ENABLE: eye_en_reg <= reg_wdata_in[BIT_EYE_EN];
            default:        ovr_reg    <= ovr_reg;
          endcase
        end
      end

      // CDR hold and restart; restart needs a signal to lock onto
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          hold_q             <= 1'b0;
          cdr_hold_out[i]    <= 1'b0;
          cdr_restart_out[i] <= 1'b0;
          ch_reset_out[i]    <= 1'b0;
        end else begin
          hold_q             <= ovr_reg[1] && ovr_reg[0];
          cdr_hold_out[i]    <= ovr_reg[1] && ovr_reg[0];
          cdr_restart_out[i] <= hold_q && !(ovr_reg[1] && ovr_reg[0]) && sig_det_in[i];
          ch_reset_out[i]    <= soft_rst;
        end
      end

      // Adapt mode forwarded for the adaptation engine
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          adapt_mode_out[2*i +: 2] <= RST_ADAPT_MODE;
        end else begin
          adapt_mode_out[2*i +: 2] <= adapt_reg;
        end
      end

      assign pend[i] = lol_reg || los_reg || eye_reg;

      // Read view of this channel; soft reset bit reads zero
      always_comb begin
        ch_rdata[i] = 8'h00;
        case (reg_addr_in)
          OFS_IRQ_CAUSE: begin
            ch_rdata[i][BIT_LOSS_LOCK] = lol_reg;
            ch_rdata[i][BIT_LOSS_SIG]  = los_reg;
          end
          OFS_CDR_OVR: begin
            ch_rdata[i][BIT_OVR_EN]   = ovr_reg[1];
            ch_rdata[i][BIT_OVR_HOLD] = ovr_reg[0];
          end
          OFS_EYE_STATUS: ch_rdata[i][BIT_EYE_IRQ] = eye_reg;
          OFS_ADAPT_MODE: ch_rdata[i][ADAPT_HI:ADAPT_LO] = adapt_reg;
          OFS_EYE_THRESH: ch_rdata[i] = thr_reg;
          OFS_EYE_ENABLE: ch_rdata[i][BIT_EYE_EN] = eye_en_reg;
          default:        ch_rdata[i] = 8'h00;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == OFS_CH_SELECT) begin
        rdata_reg <= {5'h00, sel_reg};
      end else if (page_ch) begin
        rdata_reg <= ch_rdata[cur_ch];
      end else if (reg_addr_in == OFS_LOAD_CTRL) begin
        rdata_reg <= {2'h0, mm_reset_reg, 5'h00};
      end else if (reg_addr_in == OFS_IRQ_FLAGS) begin
        rdata_reg <= {mm_disable_reg, 2'h0, lc.done, pend};
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  // Data is constant low so only the enable moves; wire-AND safe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      int_oe_reg <= 1'b0;
      int_n_out  <= 1'b0;
    end else begin
      int_oe_reg <= |pend;
      int_n_out  <= 1'b0;
    end
  end

  assign int_n_oe_out = int_oe_reg;
endmodule // retimer_int_and_load_ctrl

/* retimer_pkg.sv */
// Purpose: Shared constants for the retimer interrupt and load control block
// Assumes: Byte-wide register port, four channels, one 100 MHz clock
// Notes:   Rule summary follows
// Operation
// - Master-mode reset bit restarts load control
// - Pin low in master mode fetches, flags done
// - Immediate-fetch write starts fetch at once
// - Done blocks refetch until master-mode reset
// - Disable bit blocks only a pending fetch
// - Channel soft reset restores defaults, self-clears
// - Override plus hold bit resets CDR machine
// - Release restarts lock with configured adapt mode; the block restarts only while signal detect is high
// - Lock loss and signal loss always interrupt
// - Enabled eye drop below threshold interrupts
// - Reading eye status register clears its bit
// - Any pending cause pulls open-drain line low
// - Cause register flags lock, signal; read clears
// - Shared field flags each interrupting channel
// - Line releases once all status is cleared
package retimer_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SOFT_RESET  = 8'h00;
  localparam logic [7:0] OFS_IRQ_CAUSE   = 8'h01;
  localparam logic [7:0] OFS_LOAD_CTRL   = 8'h04;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h05;
  localparam logic [7:0] OFS_CDR_OVR     = 8'h0a;
  localparam logic [7:0] OFS_EYE_STATUS  = 8'h30;
  localparam logic [7:0] OFS_ADAPT_MODE  = 8'h31;
  localparam logic [7:0] OFS_EYE_THRESH  = 8'h32;
  localparam logic [7:0] OFS_EYE_ENABLE  = 8'h36;
  localparam logic [7:0] OFS_CH_SELECT   = 8'hff;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CH_SOFT_RST = 2;
  localparam int BIT_LOSS_LOCK   = 4;
  localparam int BIT_LOSS_SIG    = 0;
  localparam int BIT_MM_RESET    = 5;
  localparam int BIT_IMM_FETCH   = 4;
  localparam int BIT_MM_DISABLE  = 7;
  localparam int BIT_LOAD_DONE   = 4;
  localparam int BIT_OVR_EN      = 3;
  localparam int BIT_OVR_HOLD    = 2;
  localparam int BIT_EYE_IRQ     = 4;
  localparam int BIT_EYE_EN      = 6;
  localparam int ADAPT_HI        = 6;
  localparam int ADAPT_LO        = 5;
  localparam int BIT_PAGE_EN     = 2;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_EYE_THRESH = 8'h00;
  localparam logic [1:0] RST_ADAPT_MODE = 2'h0;
  localparam logic [2:0] RST_CH_SELECT  = 3'h0;
  // ----------------------------------------------------------------
  // Load controller states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LOAD_IDLE, LOAD_FETCH, LOAD_DONE} load_state_t;
endpackage

/* load_ctrl_if.sv */
// Purpose: Carrier between register front end and EEPROM load controller
// Assumes: Single clock domain
// Notes:   Front end drives controls, load controller returns status
`timescale 1ns/10ps
interface load_ctrl_if;
  logic imm_go;     // One-cycle immediate fetch request
  logic mm_reset;   // Master-mode reset level
  logic mm_disable; // Master-mode disable level
  logic done;       // Fetch completed
  logic fetch_req;  // Fetch in progress, to EEPROM engine
  modport front (output imm_go, output mm_reset, output mm_disable,
                 input done, input fetch_req);
  modport load  (input imm_go, input mm_reset, input mm_disable,
                 output done, output fetch_req);
endinterface // load_ctrl_if

/* eeprom_load_ctrl.sv */
// Purpose: Sequencing of configuration fetches from the external EEPROM
// Assumes: Strap and request pin synchronous to clk_in
// Notes:   The fetch engine itself lives outside and reports completion
`timescale 1ns/10ps
module eeprom_load_ctrl
  import retimer_pkg::*;
(
  input  wire logic clk_in,          // Core clock
  input  wire logic srst_in,         // Synchronous reset
  input  wire logic master_mode_in,  // Captured strap, 1 for master mode
  input  wire logic load_req_n_in,   // Load request pin, active low
  input  wire logic fetch_done_in,   // Completion from fetch engine
  load_ctrl_if.load lc               // Controls and status
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  load_state_t state_reg;  // Load sequencer state

  // Sequencer; outputs decoded from the state flop
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= LOAD_IDLE;
    end else if (lc.mm_reset) begin
      state_reg <= LOAD_IDLE;
    end else begin
      case (state_reg)
        LOAD_IDLE: begin
          if (lc.imm_go) begin
            state_reg <= LOAD_FETCH;
          end else if (master_mode_in && !lc.mm_disable && !load_req_n_in) begin
            state_reg <= LOAD_FETCH;
          end
        end
        LOAD_FETCH: begin
          // Disable and new requests are ignored mid-fetch
          if (fetch_done_in) begin
            state_reg <= LOAD_DONE;
          end
        end
        LOAD_DONE: state_reg <= LOAD_DONE;
        default:   state_reg <= LOAD_IDLE;
      endcase
    end
  end

  assign lc.done      = (state_reg == LOAD_DONE);
  assign lc.fetch_req = (state_reg == LOAD_FETCH);
endmodule // eeprom_load_ctrl

/* fetch_engine_model.sv */
// Purpose: Far-side stand-in for the EEPROM fetch engine
// Assumes: Fetch request is a level from the block
// Notes:   Answers LAT+1 cycles after the request rises; a large LAT makes it slow
`timescale 1ns/10ps
module fetch_engine_model #(
  parameter int LAT = 5                // One less than the cycles a fetch takes
) (
  input  wire logic clk_in,            // Core clock
  input  wire logic srst_in,           // Synchronous reset
  input  wire logic fetch_req_in,      // Fetch in progress
  output logic      fetch_done_out     // One-cycle completion
);
  logic [7:0] cnt_reg;                 // Cycles spent in this fetch
  // ----------------------------------
  // Completion timer
  // ----------------------------------
  // always present, always completes
  always_ff @(posedge clk_in) begin
    if (srst_in || !fetch_req_in || fetch_done_out) begin
      cnt_reg        <= 8'h00;
      fetch_done_out <= 1'b0;
    end else begin
      cnt_reg        <= cnt_reg + 8'h01;
      fetch_done_out <= (cnt_reg == LAT[7:0]);
    end
  end
endmodule // fetch_engine_model

/* retimer_int_and_load_ctrl_monitor.sv */
// Purpose: Port-level checks of the interrupt and load block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module below
`timescale 1ns/10ps
module retimer_int_and_load_ctrl_monitor (
  input wire logic       clk_in, srst_in, fetch_done_in,
  input wire logic       reg_wr_in, reg_rd_in,
  input wire logic [3:0] lock_in, sig_det_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       fetch_req_out, int_n_out, int_n_oe_out,
  input wire logic [3:0] ch_reset_out, cdr_restart_out
);
  // ----------------------------------
  // Checks
  // ----------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  AST_PULL_LOW: assert property (int_n_oe_out |-> !int_n_out)
    else $error("int data not low");
  AST_LOCK_IRQ: assert property (|($past(lock_in) & ~lock_in) |-> ##2 int_n_oe_out)
    else $error("lock loss without int");
  AST_SIG_IRQ: assert property (|($past(sig_det_in) & ~sig_det_in) |-> ##2 int_n_oe_out)
    else $error("signal loss without int");
  AST_INT_RELEASE: assert property ($fell(int_n_oe_out) |-> $past(reg_rd_in, 2) || $past(reg_wr_in, 2))
    else $error("int released without access");
  AST_FETCH_END: assert property ($fell(fetch_req_out) |->
    $past(fetch_done_in, 2) || $past(reg_wr_in, 2) || $past(reg_wr_in, 3))
    else $error("fetch aborted");
  AST_DONE_DROP: assert property (fetch_done_in && fetch_req_out |-> ##2 !fetch_req_out)
    else $error("fetch not ended");
  AST_RDATA_HOLD: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved");
  AST_RESTART_PULSE: assert property (|cdr_restart_out |=> (cdr_restart_out & $past(cdr_restart_out)) == 4'h0)
    else $error("restart not a pulse");
  AST_CHRST_PULSE: assert property (|ch_reset_out |=> (ch_reset_out & $past(ch_reset_out)) == 4'h0)
    else $error("channel reset not a pulse");
endmodule // retimer_int_and_load_ctrl_monitor
bind retimer_int_and_load_ctrl retimer_int_and_load_ctrl_monitor u_mon (
  .clk_in(clk_in), .srst_in(srst_in), .fetch_done_in(fetch_done_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .lock_in(lock_in),
  .sig_det_in(sig_det_in), .reg_rdata_out(reg_rdata_out), .fetch_req_out(fetch_req_out),
  .int_n_out(int_n_out), .int_n_oe_out(int_n_oe_out), .ch_reset_out(ch_reset_out),
  .cdr_restart_out(cdr_restart_out));

/* retimer_int_and_load_ctrl_tb.sv */
// Purpose: Self-checking bench of the interrupt and load block
// Assumes: Strap low at start, so the block starts in master mode; one scenario restarts in slave mode
// Notes:   Pulses are caught by a sticky watch, not by timing
`timescale 1ns/10ps
module retimer_int_and_load_ctrl_tb;
  import retimer_pkg::*;
  logic        clk_in = 1'b0, srst_in = 1'b1, req_n = 1'b1, wr = 1'b0, rd = 1'b0, strap = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, rv, adapt;
  logic [3:0]  lock = 4'hf, sig = 4'hf, ch_rst, hold, restart, seen;
  logic [31:0] horizontal_eye_opening = 32'hffffffff, vertical_eye_opening = 32'hffffffff;
  logic        done, fetch, int_d, int_oe, ok;
  int          err_count = 0, comparisons = 0;
  wire         int_line = int_oe ? int_d : 1'b1; // Pull-up when released
  wire [3:0]   watch = {restart[0], ch_rst[0], int_oe, fetch};
  always #5 clk_in = ~clk_in;
  // Sticky capture so short pulses are never missed
  always @(watch) seen = seen | watch;
  retimer_int_and_load_ctrl u_dut (.clk_in(clk_in), .srst_in(srst_in), .bus_role_strap_in(strap),
    .load_req_n_in(req_n), .fetch_done_in(done), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .lock_in(lock), .sig_det_in(sig),
    .horizontal_eye_opening_in(horizontal_eye_opening), .vertical_eye_opening_in(vertical_eye_opening), .reg_rdata_out(rdata),
    .fetch_req_out(fetch), .int_n_out(int_d), .int_n_oe_out(int_oe), .ch_reset_out(ch_rst),
    .cdr_hold_out(hold), .cdr_restart_out(restart), .adapt_mode_out(adapt));
  fetch_engine_model u_fetch (.clk_in(clk_in), .srst_in(srst_in), .fetch_req_in(fetch),
    .fetch_done_out(done));
  // ----------------------------------
  // Bus and check tasks
  // ----------------------------------
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_in); wr <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a);
    @(posedge clk_in); addr <= a; rd <= 1'b1;
    @(posedge clk_in); rd <= 1'b0;
    @(posedge clk_in); #1 rv = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Waits lim cycles, then judges whether watch bit k was ever seen
  task automatic see(input int k, input int lim, input logic e);
    repeat (lim) @(posedge clk_in);
    #1 ok = seen[k];
    chk("watch", {7'h0, e}, {7'h0, ok});
    if (e && ok !== 1'b1) conclude();
  endtask
  task automatic conclude();
    $display("compared %0d, mismatched %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------
  // Scenarios
  // ----------------------------------
  task automatic t_pin_fetch();
    seen = 4'h0;
    @(posedge clk_in); req_n <= 1'b0;
    see(0, 20, 1'b1);
    @(posedge clk_in); req_n <= 1'b1;
    rd8(OFS_IRQ_FLAGS); chk("load_done", 8'h10, rv);
    seen = 4'h0;
    wr8(OFS_LOAD_CTRL, 8'h10); see(0, 10, 1'b0);
    $display("test pin_fetch ended");
  endtask
  task automatic t_mm_reset();
    wr8(OFS_LOAD_CTRL, 8'h20); wr8(OFS_LOAD_CTRL, 8'h00);
    rd8(OFS_IRQ_FLAGS); chk("done_clear", 8'h00, rv);
    wr8(OFS_IRQ_FLAGS, 8'h80);
    seen = 4'h0;
    @(posedge clk_in); req_n <= 1'b0;
    see(0, 10, 1'b0);
    wr8(OFS_LOAD_CTRL, 8'h10); see(0, 20, 1'b1);
    @(posedge clk_in); req_n <= 1'b1;
    rd8(OFS_IRQ_FLAGS); chk("dis_done", 8'h90, rv);
    $display("test mm_reset ended");
  endtask
  task automatic t_irq(input logic [1:0] ch, input logic s);
    seen = 4'h0;
    @(posedge clk_in); lock[ch] <= 1'b0; sig[ch] <= s;
    see(1, 4, 1'b1);
    chk("int_line", 8'h00, {7'h0, int_line});
    rd8(OFS_IRQ_FLAGS); chk("flags", 8'h90 | (8'h01 << ch), rv);
    wr8(OFS_CH_SELECT, {6'h01, ch}); rd8(OFS_IRQ_CAUSE);
    chk("cause", {7'h08, ~s}, rv);
    rd8(OFS_IRQ_CAUSE); chk("cause_clr", 8'h00, rv);
    wr8(OFS_CH_SELECT, 8'h00); rd8(OFS_IRQ_FLAGS); chk("flag_clr", 8'h90, rv);
    chk("int_rel", 8'h01, {7'h0, int_line});
    $display("test irq ended");
  endtask
  task automatic t_eye();
    wr8(OFS_CH_SELECT, 8'h07); wr8(OFS_EYE_THRESH, 8'h40); wr8(OFS_EYE_ENABLE, 8'h40);
    seen = 4'h0;
    @(posedge clk_in); vertical_eye_opening[31:24] <= 8'h20;
    see(1, 4, 1'b1);
    rd8(OFS_EYE_STATUS); chk("eye", 8'h10, rv & 8'h10);
    rd8(OFS_EYE_STATUS); chk("eye_clr", 8'h00, rv & 8'h10);
    chk("int_rel", 8'h01, {7'h0, int_line});
    $display("test eye ended");
  endtask
  task automatic t_cdr();
    wr8(OFS_CH_SELECT, 8'h04); wr8(OFS_CDR_OVR, 8'h0c); wr8(OFS_ADAPT_MODE, 8'h60);
    // Adapt output lags the taken write by one edge
    repeat (2) @(posedge clk_in);
    #1;
    chk("hold", 8'h01, {7'h0, hold[0]});
    chk("adapt", 8'h03, {6'h0, adapt[1:0]});
    seen = 4'h0;
    wr8(OFS_CDR_OVR, 8'h08); see(3, 4, 1'b1);
    seen = 4'h0;
    wr8(OFS_SOFT_RESET, 8'h04); see(2, 4, 1'b1);
    rd8(OFS_CDR_OVR); chk("ovr_def", 8'h00, rv);
    rd8(OFS_SOFT_RESET); chk("self_clr", 8'h00, rv);
    rd8(8'h77); chk("unmapped", 8'h00, rv);
    $display("test cdr ended");
  endtask
  // Restart strapped for slave mode: pin is ignored, immediate fetch still runs
  task automatic t_slave();
    @(posedge clk_in); strap <= 1'b1; srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    seen = 4'h0;
    @(posedge clk_in); req_n <= 1'b0;
    see(0, 10, 1'b0);
    wr8(OFS_LOAD_CTRL, 8'h10); see(0, 20, 1'b1);
    @(posedge clk_in); req_n <= 1'b1;
    rd8(OFS_IRQ_FLAGS); chk("slave_done", 8'h10, rv);
    $display("test slave ended");
  endtask
  initial begin
    seen = 4'h0;
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    t_pin_fetch();
    t_mm_reset();
    t_irq(2'h1, 1'b1);
    t_irq(2'h2, 1'b0);
    t_eye();
    t_cdr();
    t_slave();
    conclude();
  end
endmodule // retimer_int_and_load_ctrl_tb
